// ===== include/flip_pkg.sv
// Constants and types shared by the four-level interrupt priority controller
package flip_pkg;

  // ****************************************************************
  // Register bus geometry and register indices (byte address = 4 * index)
  // ****************************************************************
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned DATA_W         = 32;
  localparam logic [7:0]  IDX_ENABLE     = 8'hA8;
  localparam logic [7:0]  IDX_PRIO_HIGH  = 8'hB7;
  localparam logic [7:0]  IDX_PRIO_LOW   = 8'hC0;
  localparam logic [7:0]  IDX_EVT_STATUS = 8'hC1;
  localparam logic [7:0]  IDX_EVT_MASK   = 8'hC2;
  localparam logic [7:0]  IDX_IN_SERVICE = 8'hC3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  RST_ENABLE     = 8'h00;
  localparam logic [7:0]  RST_PRIO_HIGH  = 8'h00;
  localparam logic [7:0]  RST_PRIO_LOW   = 8'h00;
  localparam logic [2:0]  RST_EVT        = 3'h0;

  // ****************************************************************
  // Enable register field positions (priority registers share them)
  // ****************************************************************
  localparam int unsigned BIT_EXT_ZERO      = 0;
  localparam int unsigned BIT_TIMER_ZERO    = 1;
  localparam int unsigned BIT_EXT_ONE       = 2;
  localparam int unsigned BIT_TIMER_ONE     = 3;
  localparam int unsigned BIT_SERIAL        = 4;
  localparam int unsigned BIT_TIMER_TWO     = 5;
  localparam int unsigned BIT_COUNTER_ARRAY = 6;
  localparam int unsigned BIT_GLOBAL        = 7;
  localparam int unsigned NUM_SOURCES       = 7;
  localparam int unsigned NUM_LEVELS        = 4;

  typedef logic [2:0] flip_src_type;
  typedef logic [1:0] flip_level_type;

  // Bit positions listed by polling rank 1 to 7
  localparam flip_src_type RANK_ORDER [NUM_SOURCES] =
    '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4, 3'h5};
  // Vector address indexed by bit position
  localparam logic [7:0] VECTOR_TABLE [NUM_SOURCES] =
    '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33};
  // Flags cleared on vectoring: always, and only in transition mode
  localparam logic [6:0] HW_CLEAR_ALWAYS = 7'h0A;
  localparam logic [6:0] HW_CLEAR_EDGE   = 7'h05;
  localparam logic [7:0] ENABLE_NO_CA    = 8'hBF;

  // ****************************************************************
  // Event status bits and in-service register fields
  // ****************************************************************
  localparam int unsigned EVT_VECTOR     = 0;
  localparam int unsigned EVT_PREEMPT    = 1;
  localparam int unsigned EVT_RESUME     = 2;
  localparam int unsigned EVT_W          = 3;
  localparam int unsigned ISR_SRC_LSB    = 4;
  localparam int unsigned ISR_BUSY_BIT   = 7;

endpackage

// ===== rtl/flip_controller.sv
// Four-level nested interrupt priority controller with APB register access
//
// Function
// - High and low bits give level 0..3
// - Grant only above every level in service
// - Equal or lower request waits for return
// - Higher level preempts lower service at once
// - Return resumes suspended level, four deep
// - Seven sources, fixed ranks and vectors
// - Variant without counter array: six sources
// - Priority high bits in own register
// - Enable register: global gate plus seven enables
// - External flag cleared only when transition mode
`timescale 1ns/1ps
module flip_controller #(
  parameter bit HAS_COUNTER_ARRAY = 1'b1
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [flip_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [flip_pkg::DATA_W-1:0]   pwdata,
  output logic      [flip_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Request flags from the sources, indexed by enable bit position
  input  wire logic [6:0]                    src_request,
  input  wire logic                          ext_zero_edge_mode,
  input  wire logic                          ext_one_edge_mode,
  // Processor core side
  input  wire logic                          core_return,
  output logic                               vector_strobe,
  output logic      [7:0]                    vector_addr,
  output logic      [6:0]                    flag_clear,
  // Interrupt to the system
  output logic                               irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]                 enable_reg,    enable_next;
  logic [7:0]                 prio_high_reg, prio_high_next;
  logic [7:0]                 prio_low_reg,  prio_low_next;
  logic [2:0]                 status_reg,    status_next;
  logic [2:0]                 mask_reg,      mask_next;
  logic [31:0]                prdata_reg,    prdata_next;
  logic                       pready_reg,    pready_next;
  logic                       pslverr_reg,   pslverr_next;
  logic                       irq_reg,       irq_next;
  logic [3:0]                 active_reg,    active_next;
  flip_pkg::flip_src_type     src_stack_reg  [4];
  flip_pkg::flip_src_type     src_stack_next [4];
  logic                       vector_strobe_reg, vector_strobe_next;
  logic [7:0]                 vector_addr_reg,   vector_addr_next;
  logic [6:0]                 flag_clear_reg,    flag_clear_next;
  flip_pkg::flip_src_type     grant_src_reg,     grant_src_next;
  flip_pkg::flip_level_type   grant_lvl_reg,     grant_lvl_next;

  // Controller combinational results
  logic [6:0]                 pend;
  logic                       any_active;
  flip_pkg::flip_level_type   top_lvl;
  logic                       found;
  flip_pkg::flip_src_type     best_src;
  flip_pkg::flip_level_type   best_lvl;
  logic                       grant_ok;
  logic [2:0]                 events;

  // Bus decode results
  logic                       wr_en;
  logic [7:0]                 word_idx;

  function automatic flip_pkg::flip_level_type level_of(input flip_pkg::flip_src_type b);
    level_of = {prio_high_reg[b], prio_low_reg[b]};
  endfunction

  // ****************************************************************
  // Arbitration and nesting
  // ****************************************************************
  always_comb
  begin
    logic [3:0] popped;
    popped = active_reg;
    pend = src_request & enable_reg[6:0] & {7{enable_reg[flip_pkg::BIT_GLOBAL]}};
    if (!HAS_COUNTER_ARRAY)
    begin
      pend[flip_pkg::BIT_COUNTER_ARRAY] = 1'b0;
    end
    any_active = |active_reg;
    top_lvl = 2'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (active_reg[l])
      begin
        top_lvl = flip_pkg::flip_level_type'(l);
      end
    end
    // Highest level wins; within a level the first rank found stays
    found = 1'b0;
    best_src = 3'h0;
    best_lvl = 2'h0;
    for (int r = 0; r < 7; r++)
    begin
      if (pend[flip_pkg::RANK_ORDER[r]] &&
          (!found || level_of(flip_pkg::RANK_ORDER[r]) > best_lvl))
      begin
        found = 1'b1;
        best_src = flip_pkg::RANK_ORDER[r];
        best_lvl = level_of(flip_pkg::RANK_ORDER[r]);
      end
    end
    grant_ok = found && (!any_active || best_lvl > top_lvl);
    active_next = active_reg;
    src_stack_next = src_stack_reg;
    if (core_return && any_active)
    begin
      popped[top_lvl] = 1'b0;
      active_next = popped;
    end
    vector_strobe_next = grant_ok;
    vector_addr_next = vector_addr_reg;
    flag_clear_next = 7'h00;
    grant_src_next = grant_src_reg;
    grant_lvl_next = grant_lvl_reg;
    if (grant_ok)
    begin
      active_next[best_lvl] = 1'b1;
      src_stack_next[best_lvl] = best_src;
      vector_addr_next = flip_pkg::VECTOR_TABLE[best_src];
      grant_src_next = best_src;
      grant_lvl_next = best_lvl;
      flag_clear_next = (7'h01 << best_src) & (flip_pkg::HW_CLEAR_ALWAYS |
                        (flip_pkg::HW_CLEAR_EDGE &
                         {4'h0, ext_one_edge_mode, 1'b0, ext_zero_edge_mode}));
    end
    events = 3'h0;
    events[flip_pkg::EVT_VECTOR] = grant_ok;
    events[flip_pkg::EVT_PREEMPT] = grant_ok && any_active;
    events[flip_pkg::EVT_RESUME] = core_return && any_active && (|popped) && !grant_ok;
  end

  // ****************************************************************
  // APB registers
  // ****************************************************************
  always_comb
  begin
    logic hit;
    logic [7:0] rd;
    hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    word_idx = paddr[9:2];
    rd = 8'h00;
    if (!hit)
    begin
      hit = 1'b0;
    end
    else if (word_idx == flip_pkg::IDX_ENABLE)
    begin
      rd = enable_reg;
    end
    else if (word_idx == flip_pkg::IDX_PRIO_HIGH)
    begin
      rd = prio_high_reg;
    end
    else if (word_idx == flip_pkg::IDX_PRIO_LOW)
    begin
      rd = prio_low_reg;
    end
    else if (word_idx == flip_pkg::IDX_EVT_STATUS)
    begin
      rd = {5'h00, status_reg};
    end
    else if (word_idx == flip_pkg::IDX_EVT_MASK)
    begin
      rd = {5'h00, mask_reg};
    end
    else if (word_idx == flip_pkg::IDX_IN_SERVICE)
    begin
      rd = {any_active, src_stack_reg[top_lvl], active_reg};
    end
    else
    begin
      hit = 1'b0;
    end
    // First access edge loads the answer; the next edge completes it
    pready_next = psel && penable && !pready_reg;
    prdata_next = pready_next ? {24'h000000, (hit ? rd : 8'h00)} : prdata_reg;
    pslverr_next = pready_next ? !hit : 1'b0;
    wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;
    enable_next = enable_reg;
    prio_high_next = prio_high_reg;
    prio_low_next = prio_low_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    if (wr_en && word_idx == flip_pkg::IDX_ENABLE)
    begin
      enable_next = pwdata[7:0] & (HAS_COUNTER_ARRAY ? 8'hFF : flip_pkg::ENABLE_NO_CA);
    end
    if (wr_en && word_idx == flip_pkg::IDX_PRIO_HIGH)
    begin
      prio_high_next = pwdata[7:0];
    end
    if (wr_en && word_idx == flip_pkg::IDX_PRIO_LOW)
    begin
      prio_low_next = pwdata[7:0];
    end
    if (wr_en && word_idx == flip_pkg::IDX_EVT_MASK)
    begin
      mask_next = pwdata[2:0];
    end
    if (wr_en && word_idx == flip_pkg::IDX_EVT_STATUS)
    begin
      status_next = status_reg & ~pwdata[2:0];
    end
    // A new event outlives a simultaneous clear
    status_next = status_next | events;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_reg        <= flip_pkg::RST_ENABLE;
      prio_high_reg     <= flip_pkg::RST_PRIO_HIGH;
      prio_low_reg      <= flip_pkg::RST_PRIO_LOW;
      status_reg        <= flip_pkg::RST_EVT;
      mask_reg          <= flip_pkg::RST_EVT;
      prdata_reg        <= 32'h00000000;
      pready_reg        <= 1'b0;
      pslverr_reg       <= 1'b0;
      irq_reg           <= 1'b0;
      active_reg        <= 4'h0;
      src_stack_reg     <= '{default: 3'h0};
      vector_strobe_reg <= 1'b0;
      vector_addr_reg   <= 8'h00;
      flag_clear_reg    <= 7'h00;
      grant_src_reg     <= 3'h0;
      grant_lvl_reg     <= 2'h0;
    end
    else
    begin
      enable_reg        <= enable_next;
      prio_high_reg     <= prio_high_next;
      prio_low_reg      <= prio_low_next;
      status_reg        <= status_next;
      mask_reg          <= mask_next;
      prdata_reg        <= prdata_next;
      pready_reg        <= pready_next;
      pslverr_reg       <= pslverr_next;
      irq_reg           <= irq_next;
      active_reg        <= active_next;
      src_stack_reg     <= src_stack_next;
      vector_strobe_reg <= vector_strobe_next;
      vector_addr_reg   <= vector_addr_next;
      flag_clear_reg    <= flag_clear_next;
      grant_src_reg     <= grant_src_next;
      grant_lvl_reg     <= grant_lvl_next;
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign vector_strobe = vector_strobe_reg;
  assign vector_addr   = vector_addr_reg;
  assign flag_clear    = flag_clear_reg;
  assign irq           = irq_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_level_map: assert property (
    vector_strobe_reg && $stable(prio_high_reg) && $stable(prio_low_reg) |->
      grant_lvl_reg == {prio_high_reg[grant_src_reg], prio_low_reg[grant_src_reg]})
    else $error("granted level does not match priority bits");

  chk_no_equal_grant: assert property (
    vector_strobe_reg |-> ($past(active_reg) >> grant_lvl_reg) == 4'h0)
    else $error("grant while equal or higher level in service");

  chk_wait_pending: assert property (
    found && any_active && best_lvl <= top_lvl |=> !vector_strobe_reg)
    else $error("request vectored over equal or higher service");

  chk_preempt_now: assert property (
    found && any_active && best_lvl > top_lvl |=>
      vector_strobe_reg && active_reg[grant_lvl_reg] &&
      $countones(active_reg) >= ($past(core_return) ? 1 : 2))
    else $error("higher request did not preempt");

  chk_resume_pop: assert property (
    core_return && any_active && !found |=>
      $countones(active_reg) == $countones($past(active_reg)) - 1)
    else $error("return did not pop exactly one level");

  chk_vec_table: assert property (
    vector_strobe_reg |-> vector_addr_reg == flip_pkg::VECTOR_TABLE[grant_src_reg])
    else $error("vector address wrong for source");

  chk_variant: assert property (
    !HAS_COUNTER_ARRAY |-> !enable_reg[6] && !(vector_strobe_reg && grant_src_reg == 3'h6))
    else $error("counter array source active in reduced build");

  chk_high_write: assert property (
    wr_en && word_idx == flip_pkg::IDX_PRIO_HIGH |=> prio_high_reg == $past(pwdata[7:0]))
    else $error("priority high register not written");

  chk_global_gate: assert property (
    !enable_reg[flip_pkg::BIT_GLOBAL] |=> !vector_strobe_reg)
    else $error("vectored while globally disabled");

  chk_edge_clear: assert property (
    vector_strobe_reg && grant_src_reg == 3'h0 |-> flag_clear_reg[0] == $past(ext_zero_edge_mode))
    else $error("external flag clear ignores trigger mode");

  chk_sw_flags: assert property (
    vector_strobe_reg |-> flag_clear_reg[6:4] == 3'h0 &&
      (grant_src_reg != 3'h1 || flag_clear_reg[1]))
    else $error("wrong hardware flag clear");

  chk_rank_tie: assert property (
    grant_ok && pend[0] && pend[1] && level_of(3'h0) == level_of(3'h1) |=>
      grant_src_reg != 3'h1)
    else $error("tie not resolved by rank");

  cov_preempt: cover property (vector_strobe_reg && $countones(active_reg) == 2);
  cov_full_nest: cover property (active_reg == 4'hF);
  cov_resume: cover property (status_reg[flip_pkg::EVT_RESUME] && irq_reg);
  cov_edge_clear: cover property (flag_clear_reg[2]);

endmodule

// ===== sim/flip_core_model.sv
// Core fetch and return logic plus request flag sources
`timescale 1ns/1ps
module flip_core_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench commands
  input  wire logic [6:0] set_req,
  input  wire logic [6:0] clr_req,
  input  wire logic       ret_cmd,
  // Controller side
  input  wire logic       vector_strobe,
  input  wire logic [7:0] vector_addr,
  input  wire logic [6:0] flag_clear,
  output logic      [6:0] src_request,
  output logic            core_return,
  // Observed grants
  output logic      [7:0] last_vec,
  output logic      [6:0] last_clr,
  output logic      [7:0] n_vec
);
  // ****************************************************************
  // Flags drop on a hardware clear; vectors are logged
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_request <= 7'h00;
      core_return <= 1'b0;
      last_vec    <= 8'h00;
      last_clr    <= 7'h00;
      n_vec       <= 8'h00;
    end
    else
    begin
      src_request <= (src_request | set_req) & ~clr_req & ~flag_clear;
      core_return <= ret_cmd;
      if (vector_strobe)
      begin
        last_vec <= vector_addr;
        last_clr <= flag_clear;
        n_vec    <= n_vec + 8'h01;
      end
    end
  end
endmodule

// ===== sim/four_level_interrupt_priority_tb_top.sv
// Self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
module four_level_interrupt_priority_tb_top;
  localparam logic [11:0] A_EN = {2'h0, flip_pkg::IDX_ENABLE, 2'h0};
  localparam logic [11:0] A_PH = {2'h0, flip_pkg::IDX_PRIO_HIGH, 2'h0};
  localparam logic [11:0] A_PL = {2'h0, flip_pkg::IDX_PRIO_LOW, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, flip_pkg::IDX_EVT_STATUS, 2'h0};
  localparam logic [11:0] A_MK = {2'h0, flip_pkg::IDX_EVT_MASK, 2'h0};
  localparam logic [11:0] A_IS = {2'h0, flip_pkg::IDX_IN_SERVICE, 2'h0};
  localparam logic [2:0]  RBIT [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4, 3'h5};
  localparam logic [7:0]  RVEC [7] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h33, 8'h23, 8'h2B};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, prdata6, rd6;
  logic        ez_mode, eo_mode;
  logic [6:0]  src_request, flag_clear, set_req, clr_req, last_clr, m;
  logic        core_return, vector_strobe, ret_cmd, err;
  logic [7:0]  vector_addr, last_vec, n_vec;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  flip_controller u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_request(src_request), .ext_zero_edge_mode(ez_mode),
    .ext_one_edge_mode(eo_mode), .core_return(core_return), .vector_strobe(vector_strobe),
    .vector_addr(vector_addr), .flag_clear(flag_clear), .irq(irq));
  flip_core_model u_core (.pclk(pclk), .presetn(presetn), .set_req(set_req),
    .clr_req(clr_req), .ret_cmd(ret_cmd), .vector_strobe(vector_strobe),
    .vector_addr(vector_addr), .flag_clear(flag_clear), .src_request(src_request),
    .core_return(core_return), .last_vec(last_vec), .last_clr(last_clr), .n_vec(n_vec));
  // Six-source build shares the bus; only its read data is looked at
  flip_controller #(.HAS_COUNTER_ARRAY(1'b0)) u_dut6 (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata6), .pready(), .pslverr(), .src_request(src_request),
    .ext_zero_edge_mode(ez_mode), .ext_one_edge_mode(eo_mode), .core_return(core_return),
    .vector_strobe(), .vector_addr(), .flag_clear(), .irq());

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The request stands until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd      = prdata;
    rd6     = prdata6;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic drive(input logic [6:0] s, input logic [6:0] c, input logic r);
    @(posedge pclk);
    set_req <= s;
    clr_req <= c;
    ret_cmd <= r;
    @(posedge pclk);
    set_req <= 7'h00;
    clr_req <= 7'h00;
    ret_cmd <= 1'b0;
  endtask

  task automatic wait_vec(input logic got, input logic [7:0] ev, input logic [6:0] ec);
    logic [7:0] start;
    int n;
    start = n_vec;
    n = 0;
    while (n_vec === start && n < 12)
    begin
      n++;
      @(negedge pclk);
    end
    chk({31'h0, n_vec !== start}, {31'h0, got});
    if (got)
    begin
      chk({24'h0, last_vec}, {24'h0, ev});
      chk({25'h0, last_clr}, {25'h0, ec});
    end
  endtask

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, ret_cmd} = 5'h00;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    set_req = 7'h00;
    clr_req = 7'h00;
    ez_mode = 1'b1;
    eo_mode = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_EN, 0); chk(rd, 32'h0);
    apb(0, A_PH, 0); chk(rd, 32'h0);
    apb(0, 12'h004, 0); chk({31'h0, err}, 32'h1);
    apb(1, A_EN, 32'h7F);
    apb(0, A_EN, 0); chk(rd, 32'h7F);
    drive(7'h02, 7'h00, 1'b0);
    wait_vec(1'b0, 8'h00, 7'h00);
    apb(1, A_EN, 32'hFF);
    wait_vec(1'b1, 8'h0B, 7'h02);
    apb(0, A_EN, 0); chk(rd, 32'hFF);
    chk(rd6, 32'hBF);
    drive(7'h00, 7'h7F, 1'b1);
    // Equal levels: the lowest rank still pending wins each round
    for (int k = 0; k < 7; k++)
    begin
      m = 7'h00;
      for (int j = k; j < 7; j++)
        m[RBIT[j]] = 1'b1;
      drive(m, 7'h00, 1'b0);
      wait_vec(1'b1, RVEC[k], (7'h01 << RBIT[k]) & 7'h0B);
      drive(7'h00, 7'h7F, 1'b1);
      repeat (3) @(posedge pclk);
    end
    // Level-mode ext0 keeps its flag; transition-mode ext1 loses it
    ez_mode <= 1'b0;
    eo_mode <= 1'b1;
    drive(7'h05, 7'h00, 1'b0);
    wait_vec(1'b1, 8'h03, 7'h00);
    drive(7'h00, 7'h01, 1'b1);
    wait_vec(1'b1, 8'h13, 7'h04);
    drive(7'h00, 7'h7F, 1'b1);
    ez_mode <= 1'b1;
    eo_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    // Levels 0 to 3 nest four deep
    apb(1, A_PH, 32'h0C);
    apb(0, A_PH, 0); chk(rd, 32'h0C);
    apb(1, A_PL, 32'h0A);
    apb(1, A_MK, 32'h02);
    for (int k = 0; k < 4; k++)
    begin
      drive(7'h01 << k, 7'h00, 1'b0);
      wait_vec(1'b1, RVEC[k], (7'h01 << k) & 7'h0B);
    end
    apb(0, A_IS, 0); chk(rd, 32'hBF);
    chk({31'h0, irq}, 32'h1);
    drive(7'h10, 7'h00, 1'b0);
    wait_vec(1'b0, 8'h00, 7'h00);
    drive(7'h00, 7'h00, 1'b1);
    repeat (3) @(posedge pclk);
    apb(0, A_IS, 0); chk(rd, 32'hA7);
    apb(0, A_ST, 0); chk(rd, 32'h7);
    apb(1, A_ST, 32'h7);
    apb(0, A_ST, 0); chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Level-mode ext1 is still raised, so it is served again above level 1
    drive(7'h00, 7'h00, 1'b1);
    wait_vec(1'b1, 8'h13, 7'h00);
    drive(7'h00, 7'h04, 1'b1);
    wait_vec(1'b0, 8'h00, 7'h00);
    drive(7'h00, 7'h00, 1'b1);
    wait_vec(1'b0, 8'h00, 7'h00);
    drive(7'h00, 7'h00, 1'b1);
    wait_vec(1'b1, 8'h23, 7'h00);
    end_sim();
  end
endmodule
